// File: include/fah_pkg.sv
// Package of constants and types for the fractional add and halving datapath
package fah_pkg;

	// ------------------------------------------------------------
	// Instruction fields
	// ------------------------------------------------------------
	localparam int MAJOR_HI = 31;
	localparam int MAJOR_LO = 26;
	localparam int SUB_HI   = 10;
	localparam int SUB_LO   = 6;
	localparam int FUNC_HI  = 5;
	localparam int FUNC_LO  = 0;

	localparam logic [5:0] MAJOR_GROUP_THREE = 6'h1f;

	localparam logic [5:0] FUNC_CLASS_UNSIGNED_QUAD_BYTE  = 6'h10;
	localparam logic [5:0] FUNC_CLASS_HALVING_ADD         = 6'h18;
	localparam logic [5:0] FUNC_CLASS_UNSIGNED_OCTAL_BYTE = 6'h14;

	localparam logic [4:0] SUB_WORD_FRAC_ADD_SAT        = 5'h16;
	localparam logic [4:0] SUB_WORD_ADD_SET_CARRY       = 5'h10;
	localparam logic [4:0] SUB_PAIR_HALF_HALVING_ADD    = 5'h08;
	localparam logic [4:0] SUB_PAIR_HALF_HALVING_ROUND  = 5'h0a;
	localparam logic [4:0] SUB_WORD_HALVING_ADD         = 5'h10;
	localparam logic [4:0] SUB_WORD_HALVING_ADD_ROUND   = 5'h12;
	localparam logic [4:0] SUB_QUAD_HALF_FRAC_ADD_WRAP  = 5'h0a;
	localparam logic [4:0] SUB_QUAD_HALF_FRAC_ADD_SAT   = 5'h0e;

	// ------------------------------------------------------------
	// Data widths and status control register layout
	// ------------------------------------------------------------
	localparam int DATA_W   = 64;
	localparam int WORD_W   = 32;
	localparam int HALF_W   = 16;
	localparam int LANES    = 4;
	localparam int STATUS_W = 32;
	localparam int OVF_BIT   = 20;
	localparam int CARRY_BIT = 13;
	localparam logic OVF_RESET   = 1'b0;
	localparam logic CARRY_RESET = 1'b0;

	// ------------------------------------------------------------
	// Operations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE                     = 4'h0,
		OP_QUAD_HALF_FRAC_ADD_WRAP  = 4'h1,
		OP_QUAD_HALF_FRAC_ADD_SAT   = 4'h2,
		OP_WORD_FRAC_ADD_SAT        = 4'h3,
		OP_PAIR_HALF_HALVING_ADD    = 4'h4,
		OP_PAIR_HALF_HALVING_ROUND  = 4'h5,
		OP_WORD_HALVING_ADD         = 4'h6,
		OP_WORD_HALVING_ADD_ROUND   = 4'h7,
		OP_WORD_ADD_SET_CARRY       = 4'h8
	} fah_op_t;

	typedef struct packed {
		logic sat;
		logic halve;
		logic round;
	} fah_lane_cfg_t;

	typedef struct packed {
		logic                valid;
		logic [31:0]         instr;
		logic [DATA_W-1:0]   rs;
		logic [DATA_W-1:0]   rt;
	} fah_req_t;

	typedef struct packed {
		logic                wr;
		logic [DATA_W-1:0]   data;
		logic                riTrap;
		logic                disTrap;
	} fah_resp_t;

	typedef struct packed {
		fah_resp_t resp;
		logic      ovf;
		logic      carry;
	} fah_state_t;

endpackage

// File: hdl/fah_lane.sv
// Signed lane adder with wrap, saturate and halving forms
`timescale 1ns/100ps
module fah_lane
	import fah_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	input  wire fah_lane_cfg_t cfg,
	output logic      [W-1:0] res,
	output logic              ovf
);

	logic [W:0] sum;
	logic [W:0] rsum;

	always_comb begin
		sum  = {a[W-1], a} + {b[W-1], b};
		rsum = sum + {{W{1'b0}}, cfg.round};
		ovf  = sum[W] ^ sum[W-1];
		if (cfg.halve) begin
			res = rsum[W:1];
		end else if (cfg.sat && ovf) begin
			// Top bit clear means positive overflow
			res = sum[W] ? {1'b1, {(W-1){1'b0}}}
			             : {1'b0, {(W-1){1'b1}}};
		end else begin
			res = sum[W-1:0];
		end
	end

endmodule

// File: hdl/fah_decode.sv
// Opcode decoder for the add group
`timescale 1ns/100ps
module fah_decode
	import fah_pkg::*;
(
	input  wire logic [31:0] instr,
	output fah_op_t          op
);

	logic [5:0] major;
	logic [5:0] func;
	logic [4:0] sub;

	always_comb begin
		major = instr[MAJOR_HI:MAJOR_LO];
		func  = instr[FUNC_HI:FUNC_LO];
		sub   = instr[SUB_HI:SUB_LO];
		op    = OP_NONE;
		if (major == MAJOR_GROUP_THREE) begin
			case (func)
				FUNC_CLASS_UNSIGNED_QUAD_BYTE: begin
					if (sub == SUB_WORD_FRAC_ADD_SAT) begin
						op = OP_WORD_FRAC_ADD_SAT;
					end else if (sub == SUB_WORD_ADD_SET_CARRY) begin
						op = OP_WORD_ADD_SET_CARRY;
					end
				end
				FUNC_CLASS_HALVING_ADD: begin
					case (sub)
						SUB_PAIR_HALF_HALVING_ADD:   op = OP_PAIR_HALF_HALVING_ADD;
						SUB_PAIR_HALF_HALVING_ROUND: op = OP_PAIR_HALF_HALVING_ROUND;
						SUB_WORD_HALVING_ADD:        op = OP_WORD_HALVING_ADD;
						SUB_WORD_HALVING_ADD_ROUND:  op = OP_WORD_HALVING_ADD_ROUND;
						default:                     op = OP_NONE;
					endcase
				end
				FUNC_CLASS_UNSIGNED_OCTAL_BYTE: begin
					if (sub == SUB_QUAD_HALF_FRAC_ADD_WRAP) begin
						op = OP_QUAD_HALF_FRAC_ADD_WRAP;
					end else if (sub == SUB_QUAD_HALF_FRAC_ADD_SAT) begin
						op = OP_QUAD_HALF_FRAC_ADD_SAT;
					end
				end
				default: op = OP_NONE;
			endcase
		end
	end

endmodule

// File: hdl/fah_alu.sv
// Single-cycle fractional add, halving add and carry add datapath
`timescale 1ns/100ps
module fah_alu
	import fah_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                arst_n,
	input  wire fah_req_t            req,
	input  wire logic                extEnable,
	input  wire logic                otherClaim,
	input  wire logic                ctrlWe,
	input  wire logic [STATUS_W-1:0] ctrlWdata,
	output fah_resp_t                resp,
	output logic [STATUS_W-1:0]      statusCtrl
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	fah_op_t op;

	fah_decode u_decode (
		.instr (req.instr),
		.op    (op)
	);

	logic hit;
	logic exec;
	logic isQuad;
	logic isPair;
	logic isWordHalve;

	always_comb begin
		hit         = req.valid && (op != OP_NONE);
		exec        = hit && extEnable;
		isQuad      = (op == OP_QUAD_HALF_FRAC_ADD_WRAP) ||
		              (op == OP_QUAD_HALF_FRAC_ADD_SAT);
		isPair      = (op == OP_PAIR_HALF_HALVING_ADD) ||
		              (op == OP_PAIR_HALF_HALVING_ROUND);
		isWordHalve = (op == OP_WORD_HALVING_ADD) ||
		              (op == OP_WORD_HALVING_ADD_ROUND);
	end

	// ------------------------------------------------------------
	// Lane configuration
	// ------------------------------------------------------------
	fah_lane_cfg_t halfCfg;
	fah_lane_cfg_t wordCfg;

	always_comb begin
		halfCfg.sat   = (op == OP_QUAD_HALF_FRAC_ADD_SAT);
		halfCfg.halve = isPair;
		halfCfg.round = (op == OP_PAIR_HALF_HALVING_ROUND);
		wordCfg.sat   = (op == OP_WORD_FRAC_ADD_SAT);
		wordCfg.halve = isWordHalve;
		wordCfg.round = (op == OP_WORD_HALVING_ADD_ROUND);
	end

	// ------------------------------------------------------------
	// Halfword lanes
	// ------------------------------------------------------------
	logic [HALF_W-1:0] laneRes [LANES];
	logic [LANES-1:0]  laneOvf;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : gLane
			fah_lane #(.W(HALF_W)) u_lane (
				.a   (req.rs[g*HALF_W +: HALF_W]),
				.b   (req.rt[g*HALF_W +: HALF_W]),
				.cfg (halfCfg),
				.res (laneRes[g]),
				.ovf (laneOvf[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Word lane and carry adder
	// ------------------------------------------------------------
	logic [WORD_W-1:0] wordRes;
	logic              wordOvf;

	fah_lane #(.W(WORD_W)) u_word (
		.a   (req.rs[WORD_W-1:0]),
		.b   (req.rt[WORD_W-1:0]),
		.cfg (wordCfg),
		.res (wordRes),
		.ovf (wordOvf)
	);

	logic [WORD_W:0] carrySum;

	always_comb begin
		carrySum = {1'b0, req.rs[WORD_W-1:0]} +
		           {1'b0, req.rt[WORD_W-1:0]};
	end

	// ------------------------------------------------------------
	// Result and flag selection
	// ------------------------------------------------------------
	logic [DATA_W-1:0] result;
	logic              setOvf;
	logic              setCarry;
	logic              carryVal;

	always_comb begin
		result   = '0;
		setOvf   = 1'b0;
		setCarry = 1'b0;
		carryVal = carrySum[WORD_W];
		case (op)
			OP_QUAD_HALF_FRAC_ADD_WRAP,
			OP_QUAD_HALF_FRAC_ADD_SAT: begin
				result = {laneRes[3], laneRes[2],
				          laneRes[1], laneRes[0]};
				setOvf = |laneOvf;
			end
			OP_WORD_FRAC_ADD_SAT: begin
				result = {{WORD_W{wordRes[WORD_W-1]}}, wordRes};
				setOvf = wordOvf;
			end
			OP_PAIR_HALF_HALVING_ADD,
			OP_PAIR_HALF_HALVING_ROUND: begin
				// Sign fill follows the formal operation, not the prose
				result = {{WORD_W{laneRes[1][HALF_W-1]}},
				          laneRes[1], laneRes[0]};
			end
			OP_WORD_HALVING_ADD,
			OP_WORD_HALVING_ADD_ROUND: begin
				result = {{WORD_W{wordRes[WORD_W-1]}}, wordRes};
			end
			OP_WORD_ADD_SET_CARRY: begin
				result = {{WORD_W{carrySum[WORD_W-1]}},
				          carrySum[WORD_W-1:0]};
				setCarry = 1'b1;
			end
			default: begin
				result = '0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State update
	// ------------------------------------------------------------
	fah_state_t state_reg;
	fah_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.resp.wr      = exec;
		state_next.resp.data    = exec ? result : state_reg.resp.data;
		// Traps depend on decode, extEnable and otherClaim, never on operand values
		state_next.resp.disTrap = hit && !extEnable;
		state_next.resp.riTrap  = req.valid && !hit && !otherClaim;
		if (ctrlWe) begin
			state_next.ovf   = ctrlWdata[OVF_BIT];
			state_next.carry = ctrlWdata[CARRY_BIT];
		end
		// Halving ops never assert either set term
		if (exec && setOvf) begin
			state_next.ovf = 1'b1;
		end
		if (exec && setCarry) begin
			state_next.carry = carryVal;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg.resp  <= '0;
			state_reg.ovf   <= OVF_RESET;
			state_reg.carry <= CARRY_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_comb begin
		resp                  = state_reg.resp;
		statusCtrl            = '0;
		statusCtrl[OVF_BIT]   = state_reg.ovf;
		statusCtrl[CARRY_BIT] = state_reg.carry;
	end

endmodule

// File: testbench/fah_alu_props.sv
// Assertion checker on the add datapath ports
`timescale 1ns/100ps
module fah_alu_props
	import fah_pkg::*;
(
	input wire logic                core_clk,
	input wire logic                arst_n,
	input wire fah_req_t            req,
	input wire logic                extEnable,
	input wire logic                otherClaim,
	input wire logic                ctrlWe,
	input wire logic [STATUS_W-1:0] ctrlWdata,
	input wire fah_resp_t           resp,
	input wire logic [STATUS_W-1:0] statusCtrl
);
	// ----------------------------------------
	// Decode model
	// ----------------------------------------
	wire logic [4:0] sub = req.instr[SUB_HI:SUB_LO];
	wire logic [5:0] fn = req.instr[FUNC_HI:FUNC_LO];
	wire logic grp = req.valid && req.instr[31:26] == 6'h1f;
	wire logic halv = grp && fn == 6'h18
		&& sub inside {5'h08, 5'h0a, 5'h10, 5'h12};
	wire logic wsat = grp && fn == 6'h10 && sub == 5'h16;
	wire logic addc = grp && fn == 6'h10 && sub == 5'h10;
	wire logic quad = grp && fn == 6'h14 && sub inside {5'h0a, 5'h0e};
	wire logic dec = halv || wsat || addc || quad;
	wire logic [32:0] sum = {1'b0, req.rs[31:0]} + {1'b0, req.rt[31:0]};
	wire logic cy = sum[32];
	wire logic aNeg = req.rs[31];
	wire logic wOvf = req.rs[31] == req.rt[31] && sum[31] != req.rs[31];

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence sWsat;
		wsat && extEnable;
	endsequence
	sequence sHalv;
		halv && extEnable && !ctrlWe;
	endsequence

	chk_dec_wr: assert property (dec && extEnable |=> resp.wr)
		else $error("decoded op gave no write");
	chk_ri_trap: assert property (
		req.valid && !dec && !otherClaim |=> resp.riTrap && !resp.wr)
		else $error("unknown op not trapped");
	chk_dis_trap: assert property (
		dec && !extEnable |=> resp.disTrap && !resp.wr)
		else $error("disabled op not trapped");
	chk_ovf_hold: assert property (
		statusCtrl[OVF_BIT] && !ctrlWe |=> statusCtrl[OVF_BIT])
		else $error("overflow flag cleared");
	chk_halve_stat: assert property (sHalv |=> $stable(statusCtrl))
		else $error("halving op changed status");
	chk_wsat_flag: assert property (
		sWsat ##0 wOvf |=> statusCtrl[OVF_BIT])
		else $error("word overflow not flagged");
	chk_wsat_clamp: assert property (
		sWsat ##0 wOvf |=> resp.data[31:0] ==
		($past(aNeg) ? 32'h80000000 : 32'h7fffffff))
		else $error("word clamp wrong");
	chk_wsat_ext: assert property (
		sWsat |=> resp.data[63:32] == {32{resp.data[31]}})
		else $error("word result not sign extended");
	chk_carry_bit: assert property (
		addc && extEnable |=> statusCtrl[CARRY_BIT] == $past(cy))
		else $error("carry bit wrong");
	chk_addc_ovf: assert property (
		addc && extEnable && !ctrlWe |=> $stable(statusCtrl[OVF_BIT]))
		else $error("carry add changed overflow flag");
endmodule

bind fah_alu fah_alu_props i_props (
	.core_clk  (core_clk),
	.arst_n    (arst_n),
	.req       (req),
	.extEnable (extEnable),
	.otherClaim(otherClaim),
	.ctrlWe    (ctrlWe),
	.ctrlWdata (ctrlWdata),
	.resp      (resp),
	.statusCtrl(statusCtrl)
);

// File: testbench/fractional_add_halve_carry_alu_tb_top.sv
// Directed testbench for the add datapath
`timescale 1ns/100ps
module fractional_add_halve_carry_alu_tb_top
	import fah_pkg::*;
;
	logic                core_clk = 1'b0;
	logic                arst_n = 1'b0;
	fah_req_t            req = '0;
	logic                extEnable = 1'b1;
	logic                otherClaim = 1'b0;
	logic                ctrlWe = 1'b0;
	logic [STATUS_W-1:0] ctrlWdata = '0;
	fah_resp_t           resp;
	logic [STATUS_W-1:0] statusCtrl;
	int                  failCount = 0;
	int                  nCompared = 0;

	always #12.5 core_clk = ~core_clk;

	fah_alu i_dut (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.req       (req),
		.extEnable (extEnable),
		.otherClaim(otherClaim),
		.ctrlWe    (ctrlWe),
		.ctrlWdata (ctrlWdata),
		.resp      (resp),
		.statusCtrl(statusCtrl)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		nCompared++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cst(input logic [31:0] e);
		cmp({32'h0, statusCtrl}, {32'h0, e});
	endtask
	function automatic logic [31:0] mk(input logic [4:0] s, input logic [5:0] f);
		return {6'h1f, 15'h0, s, f};
	endfunction
	// Valid stays up so ops run back to back; idle drops it
	task automatic op(input logic [31:0] i, input logic [63:0] a, b);
		req.instr = i;
		req.rs = a;
		req.rt = b;
		req.valid = 1'b1;
		@(posedge core_clk);
		#1;
	endtask
	task automatic idle;
		req.valid = 1'b0;
		ctrlWe = 1'b0;
		@(posedge core_clk);
		#1;
	endtask
	task automatic wctl(input logic [31:0] v);
		ctrlWe = 1'b1;
		ctrlWdata = v;
		@(posedge core_clk);
		#1;
		idle();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_quad;
		logic [63:0] a = 64'h7fff_8000_1234_ffff;
		logic [63:0] b = 64'h0001_8000_0001_0001;
		wctl(32'h0);
		op(mk(5'h0a, 6'h14), a, b);
		cmp(resp.data, 64'h8000_0000_1235_0000);
		cmp({61'h0, resp.disTrap, resp.riTrap, resp.wr}, 64'h1);
		cst(32'h0010_0000);
		op(mk(5'h0e, 6'h14), a, b);
		cmp(resp.data, 64'h7fff_8000_1235_0000);
		idle();
	endtask
	task automatic t_wsat;
		logic [31:0] w = mk(5'h16, 6'h10);
		wctl(32'h0);
		op(w, 64'h1234_5678_ffff_ffff, 64'hffff_ffff);
		cmp(resp.data, 64'hffff_ffff_ffff_fffe);
		cst(32'h0);
		op(w, 64'h7fff_ffff, 64'h1);
		cmp(resp.data, 64'h7fff_ffff);
		cst(32'h0010_0000);
		op(w, 64'h8000_0000, 64'hffff_ffff);
		cmp(resp.data, 64'hffff_ffff_8000_0000);
		op(w, 64'h1, 64'h1);
		cmp(resp.data, 64'h2);
		cst(32'h0010_0000);
		idle();
	endtask
	task automatic t_halve;
		logic [4:0] s[4] = '{5'h08, 5'h0a, 5'h10, 5'h12};
		logic [63:0] e[4] = '{64'hffffffff_80000000, 64'hffffffff_80000001,
			64'hffffffff_80008000, 64'hffffffff_80008001};
		wctl(32'h0010_2000);
		for (int k = 0; k < 4; k++) begin
			op(mk(s[k], 6'h18), 64'ha5a5a5a5_8000fffd, 64'h80000004);
			cmp(resp.data, e[k]);
			cst(32'h0010_2000);
		end
		idle();
	endtask
	task automatic t_carry;
		wctl(32'h0010_0000);
		op(mk(5'h10, 6'h10), 64'hffff_ffff, 64'h1);
		cmp(resp.data, 64'h0);
		cst(32'h0010_2000);
		op(mk(5'h10, 6'h10), 64'h7fff_ffff, 64'h1);
		cmp(resp.data, 64'hffff_ffff_8000_0000);
		cst(32'h0010_0000);
		// Status write of zeros in the same cycle: the op's set wins
		ctrlWe = 1'b1;
		ctrlWdata = 32'h0;
		op(mk(5'h10, 6'h10), 64'hffff_ffff, 64'h1);
		cst(32'h0000_2000);
		op(mk(5'h16, 6'h10), 64'h7fff_ffff, 64'h1);
		cst(32'h0010_0000);
		idle();
	endtask
	task automatic t_trap;
		wctl(32'h0);
		op(mk(5'h16, 6'h3f), 64'h0, 64'h0);
		cmp({62'h0, resp.riTrap, resp.wr}, 64'h2);
		otherClaim = 1'b1;
		op(mk(5'h16, 6'h3f), 64'h0, 64'h0);
		cmp({62'h0, resp.riTrap, resp.wr}, 64'h0);
		otherClaim = 1'b0;
		extEnable = 1'b0;
		op(mk(5'h16, 6'h10), 64'h7fff_ffff, 64'h1);
		cmp({62'h0, resp.disTrap, resp.wr}, 64'h2);
		cst(32'h0);
		extEnable = 1'b1;
		idle();
	endtask
	task automatic t_reset;
		arst_n = 1'b0;
		@(posedge core_clk);
		#1;
		cmp(resp.data, 64'h0);
		cst(32'h0);
		arst_n = 1'b1;
	endtask

	// ----------------------------------------
	// Run
	// ----------------------------------------
	task automatic final_report;
		$display("compared %0d, wrong %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
		t_quad();
		t_wsat();
		t_halve();
		t_carry();
		t_trap();
		t_reset();
		t_wsat();
		final_report();
	end
endmodule
